// ---- core/ubr_defs.svh ----
// constants for the serial break, idle and receive sampling block
// Contract
// - send_break keeps loading all-zero break frames
// - after break ends, send at least one mark
// - zero data and zero stop means break
// - break sets framing error, full, clears data
// - idle frame all ones, preamble on enable
// - disabling transmit finishes the current frame first
// - enable toggle queues one idle frame next
// - eight or nine data bits, ninth readable
// - frame done: load data, set full, irq
// - receiver samples at sixteen ticks per bit
// - resync after start and falling data edges
// - start search: zero after three ones
// - verify start on ticks three, five, seven
// - data bit is majority of eight-ten
// - high mid samples in start: noise only
// - stop bit majority, zero means framing error
// - rejected glitch never sets the noise flag
// - framing error rises with receive full
// - preamble is ten or eleven ones
`ifndef UBR_DEFS_SVH
`define UBR_DEFS_SVH

// ----------------------------------------------------------------
// register word indices, decoded from address bits 7:2
// ----------------------------------------------------------------
`define UBR_ADR_BAUD 6'h00
`define UBR_ADR_CTRL 6'h01
`define UBR_ADR_STAT 6'h02
`define UBR_ADR_DHI 6'h03
`define UBR_ADR_DLO 6'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UBR_CTL_TX_ON 0
`define UBR_CTL_RX_ON 1
`define UBR_CTL_SBK 2
`define UBR_CTL_WORD9 3
`define UBR_CTL_RIE 4
`define UBR_ST_TX_BUFFER_EMPTY 0
`define UBR_ST_FULL 1
`define UBR_ST_FE 2
`define UBR_ST_NF 3
`define UBR_ST_OVR 4
`define UBR_ST_ACT 5
`define UBR_DHI_R8 7
`define UBR_DHI_T8 6

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define UBR_DIV_RST 13'h0001
`define UBR_RT_LAST 5'h10
`define UBR_RT_V1 5'h03
`define UBR_RT_V2 5'h05
`define UBR_RT_V3 5'h07
`define UBR_RT_M1 5'h08
`define UBR_RT_M3 5'h0A
`define UBR_RT_SYNC_WIN 5'h04
`define UBR_TX_RT_LAST 4'hF
`define UBR_LEN_SHORT 4'hA
`define UBR_LEN_LONG 4'hB
`define UBR_BITS_SHORT 4'h8
`define UBR_BITS_LONG 4'h9

`endif

// ---- core/ubr_pkg.sv ----
// types for the serial break, idle and receive sampling block
package ubr_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE = 3'b001,
        TX_DATA = 3'b010,
        TX_BRK = 3'b011,
        TX_MARK = 3'b100
    } ubr_tx_st_type;

    typedef enum logic [1:0] {
        RX_SEARCH = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } ubr_rx_st_type;

    typedef struct packed {
        logic [12:0] baud_cnt;
        logic rt_tick;
        logic [12:0] div;
        logic tx_on, rx_on, send_break, word9, rx_full_irq_en;
        logic tx_buffer_empty, full, fe, nf, ovr;
        logic t8, r8;
        logic [7:0] tx_lo, rx_lo;
        logic tx_on_prev, pre_pend;
        ubr_tx_st_type tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_bits, tx_rt;
        logic txd;
        ubr_rx_st_type rx_st;
        logic [4:0] rx_rt;
        logic [2:0] rx_hist, rx_vote;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
        logic rx_prev, rx_nfp;
        logic [2:0] sync;
        logic rx_lvl;
        logic ack;
        logic [31:0] dat;
    } ubr_state_type;

endpackage

// ---- core/ubr_top.sv ----
// serial break/idle transmitter and oversampled receiver with wishbone registers
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ubr_defs.svh"

module ubr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic rx_irq_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [1:0] ones3(input logic [2:0] v);
        ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction

    function automatic logic noisy3(input logic [2:0] v);
        noisy3 = (v != 3'b000) && (v != 3'b111);
    endfunction

    localparam ubr_pkg::ubr_state_type ST_RST = '{
        div: `UBR_DIV_RST,
        tx_buffer_empty: 1'b1,
        tx_sh: 11'h7FF,
        txd: 1'b1,
        sync: 3'h7,
        rx_lvl: 1'b1,
        tx_st: ubr_pkg::TX_IDLE,
        rx_st: ubr_pkg::RX_SEARCH,
        default: '0
    };

    ubr_pkg::ubr_state_type q;
    ubr_pkg::ubr_state_type d;
    logic acc;
    logic [5:0] widx;
    logic [3:0] flen;
    logic [3:0] need;
    logic [4:0] n;
    logic [2:0] v;
    logic b;
    logic [8:0] rdat;

    assign acc = wb_cyc_i & wb_stb_i & ~q.ack;
    assign widx = wb_adr_i[7:2];
    assign flen = q.word9 ? `UBR_LEN_LONG : `UBR_LEN_SHORT;
    assign need = q.word9 ? `UBR_BITS_LONG : `UBR_BITS_SHORT;
    assign n = q.rx_rt + 5'h01;
    assign v = {q.rx_vote[1:0], q.rx_lvl};
    assign b = maj3(v);
    assign rdat = q.word9 ? q.rx_sh : {1'b0, q.rx_sh[8:1]};

    always_comb begin
        d = q;
        d.ack = acc;
        d.rt_tick = 1'b0;

        // ----------------------------------------------------------------
        // oversample tick divider and pin synchroniser
        // ----------------------------------------------------------------
        // a zero divisor stops the ticks, which freezes both shifters
        if (q.div != 13'h0000) begin
            if (q.baud_cnt >= q.div - 13'h0001) begin
                d.baud_cnt = 13'h0000;
                d.rt_tick = 1'b1;
            end else begin
                d.baud_cnt = q.baud_cnt + 13'h0001;
            end
        end
        d.sync = {q.sync[1:0], rxd_i};
        if (q.sync[1] == q.sync[2]) begin
            d.rx_lvl = q.sync[2];
        end

        // ----------------------------------------------------------------
        // register access
        // ----------------------------------------------------------------
        if (acc && wb_we_i) begin
            case (widx)
                `UBR_ADR_BAUD: begin
                    if (wb_sel_i[0]) d.div[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) d.div[12:8] = wb_dat_i[12:8];
                end
                `UBR_ADR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        d.tx_on = wb_dat_i[`UBR_CTL_TX_ON];
                        d.rx_on = wb_dat_i[`UBR_CTL_RX_ON];
                        d.send_break = wb_dat_i[`UBR_CTL_SBK];
                        d.word9 = wb_dat_i[`UBR_CTL_WORD9];
                        d.rx_full_irq_en = wb_dat_i[`UBR_CTL_RIE];
                    end
                end
                `UBR_ADR_STAT: begin
                    // write one to clear; a flag set this same cycle below wins
                    if (wb_sel_i[0]) begin
                        if (wb_dat_i[`UBR_ST_FULL]) d.full = 1'b0;
                        if (wb_dat_i[`UBR_ST_FE]) d.fe = 1'b0;
                        if (wb_dat_i[`UBR_ST_NF]) d.nf = 1'b0;
                        if (wb_dat_i[`UBR_ST_OVR]) d.ovr = 1'b0;
                    end
                end
                `UBR_ADR_DHI: begin
                    if (wb_sel_i[0]) d.t8 = wb_dat_i[`UBR_DHI_T8];
                end
                `UBR_ADR_DLO: begin
                    if (wb_sel_i[0]) begin
                        d.tx_lo = wb_dat_i[7:0];
                        d.tx_buffer_empty = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (acc && !wb_we_i) begin
            d.dat = 32'h00000000;
            case (widx)
                `UBR_ADR_BAUD: d.dat[12:0] = q.div;
                `UBR_ADR_CTRL: d.dat[4:0] = {q.rx_full_irq_en, q.word9, q.send_break, q.rx_on, q.tx_on};
                `UBR_ADR_STAT: d.dat[5:0] = {q.rx_st != ubr_pkg::RX_SEARCH,
                                             q.ovr, q.nf, q.fe, q.full, q.tx_buffer_empty};
                `UBR_ADR_DHI: d.dat[7:6] = {q.r8, q.t8};
                `UBR_ADR_DLO: d.dat[7:0] = q.rx_lo;
                default: d.dat = 32'h00000000;
            endcase
        end

        // ----------------------------------------------------------------
        // transmitter
        // ----------------------------------------------------------------
        // enable edge queues idle
        d.tx_on_prev = q.tx_on;
        if (q.tx_on && !q.tx_on_prev) begin
            d.pre_pend = 1'b1;
        end
        if (q.rt_tick) begin
            d.tx_rt = q.tx_rt + 4'h1;
            if (q.tx_rt == `UBR_TX_RT_LAST) begin
                if (q.tx_bits > 4'h1) begin
                    d.tx_sh = {1'b1, q.tx_sh[10:1]};
                    d.tx_bits = q.tx_bits - 4'h1;
                end else if (!q.tx_on) begin
                    // line idles only at frame end
                    d.tx_st = ubr_pkg::TX_IDLE;
                    d.tx_sh = 11'h7FF;
                    d.tx_bits = 4'h0;
                end else if (q.pre_pend || (q.tx_on && !q.tx_on_prev)) begin
                    d.tx_st = ubr_pkg::TX_PRE;
                    d.tx_sh = 11'h7FF;
                    d.tx_bits = flen;
                    d.pre_pend = 1'b0;
                end else if (q.send_break) begin
                    d.tx_st = ubr_pkg::TX_BRK;
                    d.tx_sh = 11'h000;
                    d.tx_bits = flen;
                end else if (q.tx_st == ubr_pkg::TX_BRK) begin
                    d.tx_st = ubr_pkg::TX_MARK;
                    d.tx_sh = 11'h7FF;
                    d.tx_bits = 4'h1;
                end else if (!q.tx_buffer_empty) begin
                    d.tx_st = ubr_pkg::TX_DATA;
                    d.tx_sh = {1'b1, q.word9 ? q.t8 : 1'b1, q.tx_lo, 1'b0};
                    d.tx_bits = flen;
                    d.tx_buffer_empty = 1'b1;
                end else begin
                    d.tx_st = ubr_pkg::TX_IDLE;
                    d.tx_sh = 11'h7FF;
                    d.tx_bits = 4'h0;
                end
            end
        end
        d.txd = d.tx_sh[0];

        // ----------------------------------------------------------------
        // receiver
        // ----------------------------------------------------------------
        if (!q.rx_on) begin
            d.rx_st = ubr_pkg::RX_SEARCH;
            d.rx_hist = 3'b000;
            d.rx_rt = 5'h00;
        end else if (q.rt_tick) begin
            d.rx_hist = {q.rx_hist[1:0], q.rx_lvl};
            d.rx_rt = n;
            if ((n == `UBR_RT_V1) || (n == `UBR_RT_V2) || (n == `UBR_RT_V3) ||
                (n >= `UBR_RT_M1 && n <= `UBR_RT_M3)) begin
                d.rx_vote = v;
            end
            case (q.rx_st)
                ubr_pkg::RX_SEARCH: begin
                    d.rx_rt = 5'h00;
                    if (q.rx_hist == 3'b111 && !q.rx_lvl) begin
                        d.rx_st = ubr_pkg::RX_START;
                        d.rx_rt = 5'h01;
                        d.rx_nfp = 1'b0;
                    end
                end
                ubr_pkg::RX_START: begin
                    if (n == `UBR_RT_V3) begin
                        if (ones3(v) > 2'd1) begin
                            d.rx_st = ubr_pkg::RX_SEARCH;
                            d.rx_hist = 3'b000;
                            d.rx_rt = 5'h00;
                        end else begin
                            d.rx_nfp = (ones3(v) == 2'd1);
                        end
                    end
                    // high mid samples only mark noise
                    if (n >= `UBR_RT_M1 && n <= `UBR_RT_M3 && q.rx_lvl) begin
                        d.rx_nfp = 1'b1;
                    end
                    if (n == `UBR_RT_LAST) begin
                        // bit grid restarts at tick 16, the end of the start bit
                        d.rx_st = ubr_pkg::RX_DATA;
                        d.rx_rt = 5'h00;
                        d.rx_bits = 4'h0;
                        d.rx_prev = 1'b0;
                    end
                end
                default: begin
                    // falling edge after a one re-aligns the grid
                    if (q.rx_prev && q.rx_hist[0] && !q.rx_lvl &&
                        n <= `UBR_RT_SYNC_WIN) begin
                        d.rx_rt = 5'h01;
                        d.rx_prev = 1'b0;
                    end
                    if (n == `UBR_RT_M3) begin
                        if (noisy3(v)) d.rx_nfp = 1'b1;
                        if (q.rx_st == ubr_pkg::RX_DATA) begin
                            d.rx_sh = {b, q.rx_sh[8:1]};
                            d.rx_bits = q.rx_bits + 4'h1;
                            d.rx_prev = b;
                        end else begin
                            d.rx_st = ubr_pkg::RX_SEARCH;
                            d.rx_hist = 3'b000;
                            d.rx_rt = 5'h00;
                            d.full = 1'b1;
                            // framing error is sticky like the other flags
                            if (!b) d.fe = 1'b1;
                            if (noisy3(v)) d.nf = 1'b1;
                            if (q.full) begin
                                d.ovr = 1'b1;
                            end else begin
                                d.rx_lo = rdat[7:0];
                                d.r8 = rdat[8];
                            end
                            if (q.rx_nfp) d.nf = 1'b1;
                        end
                    end
                    if (n == `UBR_RT_LAST && q.rx_st == ubr_pkg::RX_DATA) begin
                        d.rx_rt = 5'h00;
                        if (q.rx_bits == need) d.rx_st = ubr_pkg::RX_STOP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign txd_o = q.txd;
    assign rx_irq_o = q.full & q.rx_full_irq_en;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_break_line_low: assert property (
        q.tx_st == ubr_pkg::TX_BRK |-> !txd_o)
        else $error("break frame drove a one");
    chk_mark_after_brk: assert property (
        $past(q.tx_st) == ubr_pkg::TX_BRK && q.tx_st != ubr_pkg::TX_BRK
        |-> q.tx_st == ubr_pkg::TX_MARK && txd_o)
        else $error("break not followed by a mark");
    chk_preamble_len: assert property (
        q.tx_st == ubr_pkg::TX_PRE && $past(q.tx_st) != ubr_pkg::TX_PRE
        |-> q.tx_bits == flen && txd_o)
        else $error("preamble length wrong");
    chk_start_detect: assert property (
        q.rx_on && q.rt_tick && q.rx_st == ubr_pkg::RX_SEARCH &&
        q.rx_hist == 3'b111 && !q.rx_lvl |=> q.rx_st == ubr_pkg::RX_START)
        else $error("start edge missed");
    chk_glitch_quiet: assert property (
        q.rx_st == ubr_pkg::RX_START ##1 q.rx_st == ubr_pkg::RX_SEARCH
        |-> !$rose(q.nf))
        else $error("rejected glitch set noise");
    chk_fe_with_full: assert property (
        $rose(q.fe) |-> q.full && $past(q.rx_st) == ubr_pkg::RX_STOP)
        else $error("framing error outside frame end");
    chk_break_clears: assert property (
        q.rt_tick && q.rx_on && q.rx_st == ubr_pkg::RX_STOP && n == `UBR_RT_M3 &&
        !b && rdat == 9'h000 && !q.full
        |=> q.fe && q.full && q.rx_lo == 8'h00 && !q.r8)
        else $error("break did not clear data");
    chk_rx_off_idle: assert property (
        !q.rx_on |=> q.rx_st == ubr_pkg::RX_SEARCH ##1 q.rx_st == ubr_pkg::RX_SEARCH)
        else $error("receiver left search while off");
    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");

    cov_break_rx: cover property ($rose(q.fe) && q.rx_lo == 8'h00);
    cov_preamble: cover property (q.tx_st == ubr_pkg::TX_PRE ##1 q.tx_st == ubr_pkg::TX_DATA);
    cov_noise: cover property ($rose(q.nf) && !q.fe);
    cov_mark: cover property (q.tx_st == ubr_pkg::TX_MARK);

endmodule

// ---- bench/ubr_line_model.sv ----
// far-end serial line model: frame driver on rxd, run recorder and decoder on txd
`timescale 1ns/1ps

module ubr_line_model (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    int runs[$];
    logic [7:0] got_q[$];
    int run_len = 0;
    logic lvl = 1'b1;

    initial rxd_o = 1'b1;

    // ----------------------------------------------------------------
    // txd recorder: high runs positive, low runs negative, in clocks
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (txd_i === lvl) begin
            run_len++;
        end else begin
            runs.push_back(lvl ? run_len : -run_len);
            lvl = txd_i;
            run_len = 1;
        end
    end

    // mid-bit decoder, eight data bits, lsb first
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge txd_i);
            repeat (8) @(posedge clk_i);
            if (txd_i === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (16) @(posedge clk_i);
                    b[i] = txd_i;
                end
                got_q.push_back(b);
                repeat (16) @(posedge clk_i);
            end
        end
    end

    // remote transmitter at divisor 1: one bit is 16 clocks; bit fb is inverted
    // from clock f0 to f1 of that bit to model noise, then the line returns to mark
    task automatic send(input logic [10:0] bits, input int n, input int fb,
                        input int f0, input int f1);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 16; t++) begin
                @(posedge clk_i);
                rxd_o <= (i == fb && t >= f0 && t <= f1) ? ~bits[i] : bits[i];
            end
        end
        @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask
endmodule

// ---- bench/tb_uart_break_idle_and_rx_sampling.sv ----
// self-checking bench for the break, idle and oversampled receive block
`timescale 1ns/1ps
`include "ubr_defs.svh"

module tb_uart_break_idle_and_rx_sampling;
    localparam logic [7:0] A_DIV = {`UBR_ADR_BAUD, 2'b00};
    localparam logic [7:0] A_CTL = {`UBR_ADR_CTRL, 2'b00};
    localparam logic [7:0] A_ST = {`UBR_ADR_STAT, 2'b00};
    localparam logic [7:0] A_DHI = {`UBR_ADR_DHI, 2'b00};
    localparam logic [7:0] A_LO = {`UBR_ADR_DLO, 2'b00};
    localparam logic [31:0] C_TX = 32'h1 << `UBR_CTL_TX_ON;
    localparam logic [31:0] C_RX = 32'h1 << `UBR_CTL_RX_ON;
    localparam logic [31:0] C_SBK = 32'h1 << `UBR_CTL_SBK;
    localparam logic [31:0] C_W9 = 32'h1 << `UBR_CTL_WORD9;
    localparam logic [31:0] C_RIE = 32'h1 << `UBR_CTL_RIE;

    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00, seed = 8'h5A;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat;
    logic wb_ack, txd, rxd, irq, rie_on = 1'b0;
    int n_fail = 0, tests_run = 0, cyc_n = 0;

    initial forever #12.5 clk_i = ~clk_i;

    ubr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rxd_i(rxd), .txd_o(txd), .rx_irq_o(irq));
    ubr_line_model i_line (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [31:0] exp_st(input logic full, input logic fe, input logic nf);
        return (32'(full) << `UBR_ST_FULL) | (32'(fe) << `UBR_ST_FE) | (32'(nf) << `UBR_ST_NF);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            n_fail++;
            $display("Error timeout expected finish seen hang");
            results();
        end
    end

    // classic single cycle: request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1);
        q = wb_rdat;
        // ack is sampled high one cycle after the taking edge
        check("wb ack cycles", k, 32'h2);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    task automatic wait_got(input int n);
        for (int k = 0; k < 4000 && i_line.got_q.size() < n; k++) @(posedge clk_i);
    endtask

    task automatic wait_tx_buffer_empty();
        logic [31:0] q;
        do begin
            rd(A_ST, q);
        end while (q[`UBR_ST_TX_BUFFER_EMPTY] !== 1'b1);
    endtask

    // one received frame, then flags, data and irq compared and flags cleared
    task automatic rx(input logic [8:0] d, input logic nine, input logic stp, input int fb,
                      input int f0, input int f1, input logic enf);
        logic [31:0] q;
        logic [10:0] f;
        f = nine ? {stp, d, 1'b0} : {1'b0, stp, d[7:0], 1'b0};
        i_line.send(f, nine ? 11 : 10, fb, f0, f1);
        repeat (4) @(posedge clk_i);
        rd(A_ST, q);
        check("rx status", q & 32'h1E, exp_st(1'b1, ~stp, enf));
        check("rx irq", irq, rie_on);
        rd(A_LO, q);
        check("rx data", q & 32'hFF, {24'h0, d[7:0]});
        rd(A_DHI, q);
        if (nine) check("rx ninth", q[`UBR_DHI_R8], d[8]);
        wr(A_ST, 32'h1E);
        rd(A_ST, q);
        check("rx clear", q & 32'h1E, 32'h0);
        check("irq clear", irq, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        int t;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_ST, q);
        check("status reset", q, 32'h1);
        rd(A_CTL, q);
        check("control reset", q, 32'h0);
        rd(A_DIV, q);
        check("divisor reset", q, 32'h1);
        rd(8'h40, q);
        check("unmapped read", q, 32'h0);
        wr(A_DHI, 32'h40);
        rd(A_DHI, q);
        check("tx ninth bit", q & 32'h40, 32'h40);
        wr(A_DIV, 32'h1);
        wr(A_CTL, C_RX | C_RIE);
        rie_on = 1'b1;
        rx(9'h0A5, 1'b0, 1'b1, -1, 0, 0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            rx({1'b0, seed}, 1'b0, 1'b1, -1, 0, 0, 1'b0);
        end
        rx(9'h000, 1'b0, 1'b0, -1, 0, 0, 1'b0);
        rx(9'h0C3, 1'b0, 1'b0, -1, 0, 0, 1'b0);
        // noise bursts last two clocks: the pin filter drops single-clock pulses
        rx(9'h05A, 1'b0, 1'b1, 0, 2, 3, 1'b1);
        rx(9'h05A, 1'b0, 1'b1, 0, 8, 9, 1'b1);
        rx(9'h05A, 1'b0, 1'b1, 3, 9, 10, 1'b1);
        rx(9'h05A, 1'b0, 1'b1, 9, 9, 10, 1'b1);
        wr(A_CTL, C_RX | C_W9);
        rie_on = 1'b0;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            rx({seed[0], seed}, 1'b1, 1'b1, -1, 0, 0, 1'b0);
        end
        rx(9'h000, 1'b1, 1'b0, -1, 0, 0, 1'b0);
        wr(A_CTL, C_RX);
        i_line.send(11'h001, 1, 0, 0, 1);
        repeat (40) @(posedge clk_i);
        rd(A_ST, q);
        check("glitch status", q & 32'h1E, 32'h0);
        wr(A_CTL, 32'h0);
        i_line.send(11'h2AA, 10, -1, 0, 0);
        rd(A_ST, q);
        check("rx off status", q & 32'h1E, 32'h0);
        wr(A_CTL, C_RX);
        rx(9'h0E7, 1'b0, 1'b1, -1, 0, 0, 1'b0);
        // transmit: preamble of ten marks before the first data frame
        wr(A_CTL, C_RX | C_TX);
        wr(A_LO, 32'hA5);
        t = 0;
        while (txd !== 1'b0 && t < 400) begin
            @(posedge clk_i);
            t++;
        end
        check("preamble length", t >= 155 && t <= 180, 32'h1);
        wait_got(1);
        check("tx first byte", i_line.got_q[0], 32'hA5);
        i_line.got_q.delete();
        wr(A_LO, 32'h55);
        wait_tx_buffer_empty();
        repeat (20) @(posedge clk_i);
        i_line.runs.delete();
        // enable toggled while the buffer is empty, well before the stop bit
        wr(A_CTL, C_RX);
        wr(A_CTL, C_RX | C_TX);
        wr(A_LO, 32'h0F);
        wait_got(2);
        check("tx byte a", i_line.got_q[0], 32'h55);
        check("tx byte b", i_line.got_q[1], 32'h0F);
        t = 0;
        foreach (i_line.runs[i]) if (i_line.runs[i] > t) t = i_line.runs[i];
        check("idle gap", t, 32'h0B0);
        i_line.got_q.delete();
        wr(A_LO, 32'hC3);
        wait_tx_buffer_empty();
        wr(A_CTL, C_RX);
        wait_got(1);
        check("tx finish", i_line.got_q[0], 32'hC3);
        repeat (200) @(posedge clk_i);
        check("tx idle", txd, 32'h1);
        wr(A_CTL, C_RX | C_TX);
        wr(A_CTL, C_RX | C_TX | C_SBK);
        i_line.runs.delete();
        repeat (500) @(posedge clk_i);
        wr(A_CTL, C_RX | C_TX);
        wr(A_LO, 32'hFF);
        for (int k = 0; k < 2000 && !(i_line.got_q.size() > 0 && i_line.got_q[$] == 8'hFF); k++)
            @(posedge clk_i);
        t = 0;
        foreach (i_line.runs[i]) begin
            if (t == 0 && i_line.runs[i] < -100 && i + 1 < i_line.runs.size()) begin
                t = 1;
                check("break length", (-i_line.runs[i]) % 160, 32'h0);
                check("break mark", i_line.runs[i + 1] >= 16, 32'h1);
            end
        end
        check("break seen", t, 32'h1);
        check("byte after break", i_line.got_q[$], 32'hFF);
        results();
    end
endmodule
